// >>> rtl/opc_map.vh
// register offsets, field positions and reset values of the output port
`ifndef OPC_MAP_VH
`define OPC_MAP_VH
`define OPC_ADR_CLKOUT 4'h0
`define OPC_ADR_FLOAT 4'h4
`define OPC_ADR_DATA 4'h8
`define OPC_ADR_TIMER 4'hC
`define OPC_SEL_LO_BIT 0
`define OPC_SEL_HI_BIT 1
`define OPC_OSC_EN_BIT 3
`define OPC_TMR_EN_BIT 2
`define OPC_RST_DATA 4'hF
`define OPC_RST_FLOAT 4'h0
`define OPC_RST_CLKOUT 4'h0
`define OPC_RST_TIMER 4'h0
`define OPC_SEL_OSC 2'h3
`define OPC_SEL_PRS 2'h2
`define OPC_SEL_DIV64 2'h1
`define OPC_SEL_DIV512 2'h0
`define OPC_DIV64_MSB 5
`define OPC_DIV512_MSB 8
`endif

// >>> rtl/opc_divider.v
// synchronous divider of the prescaler clock, giving fprs/64 and fprs/512
`timescale 1ns/1ps
`include "opc_map.vh"
module opc_divider (
  input wire prs_clk,
  input wire rst_b,
  output wire div64,
  output wire div512
);
  reg [8:0] cnt_q;
  wire [8:0] cnt_d;
  assign cnt_d = cnt_q + 9'h001;
  always @(posedge prs_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign div64 = cnt_q[`OPC_DIV64_MSB];
  assign div512 = cnt_q[`OPC_DIV512_MSB];
endmodule

// >>> rtl/opc_port.v
// four-bit output port with timer and oscillator clock outputs on bits 2 and 3
`timescale 1ns/1ps
`include "opc_map.vh"
module opc_port (
  input wire MCLK,
  input wire RST_B,
  input wire OSC_CLK,
  input wire PRS_CLK,
  input wire TIMER_CLK,
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [3:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  output reg [3:0] PORT_LEVEL,
  output reg [3:0] PORT_OE
);
  // control registers and their next values
  reg [3:0] out_data_q;
  reg [3:0] out_data_d;
  reg [3:0] out_float_q;
  reg [3:0] out_float_d;
  reg osc_clock_out_en_q;
  reg osc_clock_out_en_d;
  reg clk_out_sel_hi_q;
  reg clk_out_sel_hi_d;
  reg clk_out_sel_lo_q;
  reg clk_out_sel_lo_d;
  reg timer_clock_out_en_q;
  reg timer_clock_out_en_d;

  // bus answer
  reg ack_d;
  reg [31:0] dat_d;
  reg [31:0] rd_d;

  // terminal path
  reg osc_clk_sel;
  wire [3:0] level_d;
  wire [3:0] oe_d;
  wire [3:0] special_on;
  wire [3:0] special_clk;
  wire div64;
  wire div512;
  wire [1:0] sel;

  // address decode and write fields
  wire req;
  wire wr;
  wire lane0;

  wire hit_clkout;
  wire hit_float;
  wire hit_data;
  wire hit_timer;

  wire wr_clkout;
  wire wr_float;
  wire wr_data;
  wire wr_timer;

  wire [3:0] wv_data;
  wire [3:0] wv_float;
  wire wv_osc_en;
  wire wv_sel_hi;
  wire wv_sel_lo;
  wire wv_tmr_en;

  wire [3:0] rb_clkout;
  wire [3:0] rb_float;
  wire [3:0] rb_data;
  wire [3:0] rb_timer;
  genvar i;

  // no new request while the answer to the last one still stands
  assign req = CYC_I & STB_I & ~ACK_O;
  // lane 0 holds every control bit; other lanes alone write nothing
  assign lane0 = SEL_I[0];
  assign wr = req & WE_I & lane0;
  assign hit_clkout = (ADR_I == `OPC_ADR_CLKOUT);
  assign hit_float = (ADR_I == `OPC_ADR_FLOAT);
  assign hit_data = (ADR_I == `OPC_ADR_DATA);
  assign hit_timer = (ADR_I == `OPC_ADR_TIMER);
  assign wr_clkout = wr & hit_clkout;
  assign wr_float = wr & hit_float;
  assign wr_data = wr & hit_data;
  assign wr_timer = wr & hit_timer;
  assign sel = {clk_out_sel_hi_q, clk_out_sel_lo_q};

  // write fields; only the low nibble of lane 0 is wired
  assign wv_data = DAT_I[3:0];
  assign wv_float = DAT_I[3:0];
  assign wv_osc_en = DAT_I[`OPC_OSC_EN_BIT];
  assign wv_sel_hi = DAT_I[`OPC_SEL_HI_BIT];
  assign wv_sel_lo = DAT_I[`OPC_SEL_LO_BIT];
  assign wv_tmr_en = DAT_I[`OPC_TMR_EN_BIT];

  // read-back images; bit 2 of the clock-out word is unused and reads 0
  assign rb_clkout = {osc_clock_out_en_q, 1'b0, clk_out_sel_hi_q, clk_out_sel_lo_q};
  assign rb_float = out_float_q;
  assign rb_data = out_data_q;
  assign rb_timer = {1'b0, timer_clock_out_en_q, 2'b00};

  opc_divider u_div (
    .prs_clk(PRS_CLK),
    .rst_b(RST_B),
    .div64(div64),
    .div512(div512)
  );
  // divider runs in the prescaler domain; its taps are only sampled here

  // next values of the control registers
  always @* begin
    if (wr_data) begin
      out_data_d = wv_data;
    end else begin
      out_data_d = out_data_q;
    end
  end

  always @* begin
    if (wr_float) begin
      out_float_d = wv_float;
    end else begin
      out_float_d = out_float_q;
    end
  end

  always @* begin
    if (wr_clkout) begin
      osc_clock_out_en_d = wv_osc_en;
    end else begin
      osc_clock_out_en_d = osc_clock_out_en_q;
    end
  end

  always @* begin
    if (wr_clkout) begin
      clk_out_sel_hi_d = wv_sel_hi;
    end else begin
      clk_out_sel_hi_d = clk_out_sel_hi_q;
    end
  end

  always @* begin
    if (wr_clkout) begin
      clk_out_sel_lo_d = wv_sel_lo;
    end else begin
      clk_out_sel_lo_d = clk_out_sel_lo_q;
    end
  end

  always @* begin
    if (wr_timer) begin
      timer_clock_out_en_d = wv_tmr_en;
    end else begin
      timer_clock_out_en_d = timer_clock_out_en_q;
    end
  end

  // one-cycle answer; read data stands only beside ack
  always @* begin
    ack_d = req;
  end

  // zero outside the ack cycle keeps a stale read off the bus
  always @* begin
    if (req) begin
      dat_d = rd_d;
    end else begin
      dat_d = 32'h00000000;
    end
  end

  // read mux; unmapped offsets read zero, reads never change state
  always @* begin
    rd_d = 32'h00000000;
    case (ADR_I)
      `OPC_ADR_CLKOUT: begin
        rd_d[3:0] = rb_clkout;
      end
      `OPC_ADR_FLOAT: begin
        rd_d[3:0] = rb_float;
      end
      `OPC_ADR_DATA: begin
        rd_d[3:0] = rb_data;
      end
      `OPC_ADR_TIMER: begin
        rd_d[3:0] = rb_timer;
      end
      default: begin
        rd_d = 32'h00000000;
      end
    endcase
  end

  // register flops
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      out_data_q <= `OPC_RST_DATA;
    end else begin
      out_data_q <= out_data_d;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      out_float_q <= `OPC_RST_FLOAT;
    end else begin
      out_float_q <= out_float_d;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      osc_clock_out_en_q <= 1'b0;
    end else begin
      osc_clock_out_en_q <= osc_clock_out_en_d;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      clk_out_sel_hi_q <= 1'b0;
    end else begin
      clk_out_sel_hi_q <= clk_out_sel_hi_d;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      clk_out_sel_lo_q <= 1'b0;
    end else begin
      clk_out_sel_lo_q <= clk_out_sel_lo_d;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      timer_clock_out_en_q <= 1'b0;
    end else begin
      timer_clock_out_en_q <= timer_clock_out_en_d;
    end
  end

  // bus answer flops
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= ack_d;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      DAT_O <= 32'h00000000;
    end else begin
      DAT_O <= dat_d;
    end
  end

  // clock source select
  always @* begin
    case (sel)
      `OPC_SEL_OSC: begin
        osc_clk_sel = OSC_CLK;
      end
      `OPC_SEL_PRS: begin
        osc_clk_sel = PRS_CLK;
      end
      `OPC_SEL_DIV64: begin
        osc_clk_sel = div64;
      end
      `OPC_SEL_DIV512: begin
        osc_clk_sel = div512;
      end
      default: begin
        osc_clk_sel = div512;
      end
    endcase
  end

  // only bits 2 and 3 have a special source; the others see a steady high
  assign special_on[0] = 1'b0;
  assign special_on[1] = 1'b0;
  assign special_on[2] = timer_clock_out_en_q;
  assign special_on[3] = osc_clock_out_en_q;
  assign special_clk[0] = 1'b1;
  assign special_clk[1] = 1'b1;
  assign special_clk[2] = TIMER_CLK;
  assign special_clk[3] = osc_clk_sel;

  // enables are not aligned to clock phases, so switching may cut a pulse
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_bit
      wire data_bit;
      wire float_bit;
      wire gate_open;
      assign data_bit = out_data_q[i];
      assign float_bit = out_float_q[i];
      // data 0 forces low even with a clock selected
      assign gate_open = ~special_on[i] | special_clk[i];
      assign level_d[i] = data_bit & gate_open;
      // float wins over data and clock alike
      assign oe_d[i] = ~float_bit;
    end
  endgenerate

  // clocks sampled by MCLK keep outputs registered; fast sources alias, a known limit
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PORT_LEVEL <= `OPC_RST_DATA;
    end else begin
      PORT_LEVEL <= level_d;
    end
  end

  // reset drives every terminal, so all come up high
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PORT_OE <= ~`OPC_RST_FLOAT;
    end else begin
      PORT_OE <= oe_d;
    end
  end
endmodule

// >>> sim/opc_props.sv
// assertion checker of the output port
`timescale 1ns/1ps
module opc_props(input wire MCLK, input wire RST_B, input wire CYC_I, input wire STB_I,
  input wire WE_I, input wire [3:0] ADR_I, input wire [3:0] SEL_I, input wire [31:0] DAT_I,
  input wire [31:0] DAT_O, input wire ACK_O, input wire [3:0] PORT_LEVEL,
  input wire [3:0] PORT_OE);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  wire wr = ACK_O & WE_I & SEL_I[0];
  property p_ack; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_one; ACK_O |=> !ACK_O; endproperty
  a_one: assert property (p_one) else $error("ack long");
  property p_rst; $rose(RST_B) |-> PORT_LEVEL == 4'hF && PORT_OE == 4'hF; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_oe; wr && ADR_I == 4'h4 |=> PORT_OE == ~$past(DAT_I[3:0]); endproperty
  a_oe: assert property (p_oe) else $error("float write");
  property p_lvl; wr && ADR_I == 4'h8 |=> PORT_LEVEL[1:0] == $past(DAT_I[1:0]); endproperty
  a_lvl: assert property (p_lvl) else $error("data write");
  property p_low; wr && ADR_I == 4'h8 |=> (PORT_LEVEL[3:2] & ~$past(DAT_I[3:2])) == 2'h0;
  endproperty
  a_low: assert property (p_low) else $error("low not held");
  property p_hold; !ACK_O |=> $stable(PORT_OE); endproperty
  a_hold: assert property (p_hold) else $error("float moved");
  property p_rd; ACK_O && !WE_I && ADR_I == 4'h4 |-> DAT_O[3:0] == ~PORT_OE; endproperty
  a_rd: assert property (p_rd) else $error("float read");
  c_tmr: cover property (wr && ADR_I == 4'hC);
  c_osc: cover property (wr && ADR_I == 4'h0);
  c_rise: cover property ($rose(PORT_LEVEL[3]));
endmodule
bind opc_port opc_props u_chk(.MCLK(MCLK), .RST_B(RST_B), .CYC_I(CYC_I), .STB_I(STB_I),
  .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .PORT_LEVEL(PORT_LEVEL), .PORT_OE(PORT_OE));

// >>> sim/opc_src.sv
// oscillator, prescaler and timer clock sources
`timescale 1ns/1ps
module opc_src(output logic osc, output logic prs, output logic tmr);
  // offset start keeps edges away from mclk edges
  initial begin
    osc = 1'h0; prs = 1'h0; tmr = 1'h0;
    #13;
    fork forever #150 osc = ~osc; forever #200 prs = ~prs; forever #500 tmr = ~tmr; join
  end
endmodule

// >>> sim/tb_top.sv
// testbench of the output port
`timescale 1ns/1ps
module tb_top;
  logic MCLK = 1'h0, RST_B = 1'h0, CYC_I = 1'h0, STB_I = 1'h0, WE_I = 1'h0, ACK_O;
  logic OSC_CLK, PRS_CLK, TIMER_CLK;
  logic [3:0] ADR_I = 4'h0, SEL_I = 4'h0, PORT_LEVEL, PORT_OE;
  logic [31:0] DAT_I = 32'h0, DAT_O, q;
  int failures = 0, n_compared = 0, cyc = 0;
  opc_src src(.osc(OSC_CLK), .prs(PRS_CLK), .tmr(TIMER_CLK));
  opc_port dut(.MCLK(MCLK), .RST_B(RST_B), .OSC_CLK(OSC_CLK), .PRS_CLK(PRS_CLK),
    .TIMER_CLK(TIMER_CLK), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .PORT_LEVEL(PORT_LEVEL),
    .PORT_OE(PORT_OE));
  initial forever #50 MCLK = ~MCLK;
  always @(posedge MCLK) if (++cyc > 40000) begin failures++; wrap_up; end
  task wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    CYC_I <= 1'h1; STB_I <= 1'h1; WE_I <= w; ADR_I <= a; SEL_I <= 4'hF; DAT_I <= d;
    do @(posedge MCLK); while (ACK_O !== 1'h1);
    q = DAT_O;
    CYC_I <= 1'h0; STB_I <= 1'h0;
    @(posedge MCLK);
  endtask
  // counts terminal rises over a window; clocks are sampled so allow slack
  task rises(input int b, input int e, input int w);
    int n, t;
    logic p;
    n = 0; t = (e >> 9) + (e > 0); p = PORT_LEVEL[b];
    repeat (w) begin @(posedge MCLK); n += (PORT_LEVEL[b] & !p); p = PORT_LEVEL[b]; end
    chk("rises", n >= e - t && n <= e + t, 1'h1);
  endtask
  initial begin
    int ex[4] = '{2, 16, 1024, 1365};
    repeat (8) @(posedge MCLK);
    RST_B <= 1'h1;
    @(posedge MCLK);
    chk("reset level", {PORT_LEVEL, PORT_OE}, 8'hFF);
    acc(0, 4'h8, 0); chk("data rd", q, 4'hF);
    acc(1, 4'h4, 4'h5); chk("oe", PORT_OE, 4'hA);
    acc(0, 4'h4, 0); chk("float rd", q, 4'h5);
    acc(1, 4'h4, 0); acc(1, 4'h8, 4'h6); chk("level", PORT_LEVEL, 4'h6);
    acc(1, 4'h8, 4'hF); acc(1, 4'h1, 4'hF); acc(0, 4'h1, 0); chk("unmapped", q, 0);
    acc(1, 4'hC, 4'h4); rises(2, 409, 4096);
    acc(1, 4'h8, 4'hB); rises(2, 0, 40);
    acc(1, 4'h8, 4'hF); acc(1, 4'hC, 0); rises(2, 0, 40);
    for (int s = 0; s < 4; s++) begin acc(1, 4'h0, 32'h8 + s); rises(3, ex[s], 4096); end
    acc(0, 4'h0, 0); chk("clkout rd", q, 4'hB);
    acc(1, 4'h4, 4'h8); chk("oe", PORT_OE, 4'h7);
    acc(1, 4'h4, 0); acc(1, 4'h0, 0); rises(3, 0, 40);
    chk("idle level", PORT_LEVEL, 4'hF);
    wrap_up;
  end
endmodule
